// ### core/slmc_mode_control.sv
/*
 * Mode control of a subscriber line interface: decodes the parallel
 * mode pins, drives the line stage controls, hook status, reversal
 * ramp, metering envelope, battery target and converter clock.
 * Assumes every pin input is asynchronous to clk_in and that the
 * analog stages act on the registered control outputs.
 */
// Notes on behaviour
// - Both mode bits low: power-down input low is power down, high is hi-z.
// - Power-down high, bit B set: active; A adds metering; polarity bit selects.
// - A high, B low is ring; polarity follows each controller toggle.
// - Hook status output is active low.
// - Converter clock follows external 125 kHz, or internal when strapped.
// - Battery target -50 V normally, -70 V while ring is in effect (not while overheat forces power down).
// - Power down: drivers off, wires high impedance, detectors off.
// - Overtemperature forces power down, then returns to the selected mode.
// - Hi-z mode keeps monitoring and reports off-hook low.
// - Hi-z uses the same off-hook threshold as active.
// - Voice transmission only in active mode.
// - Gain bit picks 0/-6 dB, x50 or +6/-12 dB, x25.
// - Polarity change ramps rather than steps; ramp time is adjustable.
// - Bit A gates metering; pulse lasts while set and through the envelope decay; envelope-shaped square wave.
// - Ring trip drives hook status low; controller then leaves ring.
`default_nettype none

module slmc_mode_control
   import slmc_pkg::*;
#(
   parameter int RAMP_W = 8,
   parameter int RAMP_STEP_CYC = 40,
   parameter int ENV_W = 6,
   parameter int ENV_STEP_CYC = 100
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic resetn_in,
   // Control pins from the line card controller
   input wire logic power_down_input_in,
   input wire logic mode_select_bit_a_in,
   input wire logic mode_select_bit_b_in,
   input wire logic polarity_ring_bit_in,
   input wire logic gain_select_in,
   input wire logic metering_tone_clock_in,
   // Converter clock pin and its strap to the supply filter pin
   input wire logic switch_clock_in,
   input wire logic clock_tied_to_filter_in,
   // Analog supervision
   input wire logic temp_above_limit_in,
   input wire logic temp_below_hyst_in,
   input wire logic offhook_detect_in,
   input wire logic ring_trip_detect_in,
   // Hook status open-drain pin
   output logic hook_status_n_out,
   output logic hook_status_oe_n_out,
   // Line stage and transmission
   output slmc_state_type mode_out,
   output slmc_line_ctrl_type line_ctrl_out,
   output slmc_gain_type gain_out,
   output logic signed [7:0] battery_target_out,
   output logic overheat_out,
   // Reversal ramp and metering
   output logic [RAMP_W-1:0] reversal_ramp_out,
   output logic [ENV_W-1:0] metering_envelope_out,
   output logic metering_pulse_out,
   // Converter switching clock
   output logic switch_clock_out
);

   // ****************************************
   // Input synchronisers
   // ****************************************
   slmc_pins_type pins_raw;
   slmc_pins_type pins_meta;
   slmc_pins_type pins;
   logic strap_meta;
   logic strap;

   assign pins_raw = '{
      power_down_input: power_down_input_in,
      mode_select_bit_a: mode_select_bit_a_in,
      mode_select_bit_b: mode_select_bit_b_in,
      polarity_ring_bit: polarity_ring_bit_in,
      gain_select: gain_select_in,
      metering_tone_clock: metering_tone_clock_in,
      ext_switch_clock: switch_clock_in,
      temp_above_limit: temp_above_limit_in,
      temp_below_hyst: temp_below_hyst_in,
      offhook_detect: offhook_detect_in,
      ring_trip_detect: ring_trip_detect_in
   };

   // Two stages; only the second stage is read by logic
   always_ff @(posedge clk_in) begin
      pins_meta <= pins_raw;
      pins <= pins_meta;
      strap_meta <= clock_tied_to_filter_in;
      strap <= strap_meta;
   end

   // ****************************************
   // Mode pin settling
   // ****************************************
   // Several pins may change on different edges; act only once stable
   logic [2:0] cmd_now;
   logic [2:0] cmd_prev;
   logic [3:0] settle_cnt;
   logic [3:0] next_settle_cnt;
   logic settled;

   assign cmd_now = {pins.power_down_input, pins.mode_select_bit_a,
                     pins.mode_select_bit_b};
   // Needs an unchanged code too, or the first cycle of a new code would load
   assign settled = (settle_cnt == 4'(SLMC_SETTLE_CYC)) && (cmd_now == cmd_prev);
   assign next_settle_cnt = (cmd_now != cmd_prev) ? SLMC_SETTLE_RST :
                            settled ? settle_cnt : settle_cnt + 4'h1;

   // Settle counter restarts on any change of the mode pins
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         cmd_prev <= 3'h0;
         settle_cnt <= SLMC_SETTLE_RST;
      end else begin
         cmd_prev <= cmd_now;
         settle_cnt <= next_settle_cnt;
      end
   end

   // ****************************************
   // Mode decode
   // ****************************************
   // Undefined codes with power-down low fall back to power down
   logic dec_pdown;
   logic dec_hiz;
   logic dec_active;
   logic dec_ring;
   slmc_state_type dec_state;

   assign dec_pdown = !cmd_now[2];
   assign dec_hiz = cmd_now[2] && !cmd_now[1] && !cmd_now[0];
   assign dec_active = cmd_now[2] && cmd_now[0];
   assign dec_ring = cmd_now[2] && cmd_now[1] && !cmd_now[0];
   assign dec_state = dec_pdown ? SLMC_ST_PDOWN :
                      dec_hiz ? SLMC_ST_HIZ :
                      dec_ring ? SLMC_ST_RING : SLMC_ST_ACTIVE;

   // ****************************************
   // Selected mode and thermal override
   // ****************************************
   slmc_state_type sel_state;
   slmc_state_type eff_state;
   logic overheat;
   logic next_overheat;

   // Overheat sets above the limit, clears only below the hysteresis
   assign next_overheat = pins.temp_above_limit ? 1'b1 :
                          pins.temp_below_hyst ? 1'b0 : overheat;
   // Selected mode is kept, so cooling resumes it automatically
   assign eff_state = overheat ? SLMC_ST_PDOWN : sel_state;

   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         sel_state <= SLMC_ST_PDOWN;
         overheat <= 1'b0;
      end else begin
         if (settled) begin
            sel_state <= dec_state;
         end
         overheat <= next_overheat;
      end
   end

   // ****************************************
   // Line stage controls and gains
   // ****************************************
   slmc_line_ctrl_type next_line_ctrl;
   slmc_gain_type next_gain;
   logic in_pdown;
   logic in_hiz;
   logic in_active;
   logic in_ring;

   assign in_pdown = (eff_state == SLMC_ST_PDOWN);
   assign in_hiz = (eff_state == SLMC_ST_HIZ);
   assign in_active = (eff_state == SLMC_ST_ACTIVE);
   assign in_ring = (eff_state == SLMC_ST_RING);

   assign next_line_ctrl.driver_on = !in_pdown;
   assign next_line_ctrl.wires_hiz = in_pdown;
   assign next_line_ctrl.detector_on = !in_pdown;
   assign next_line_ctrl.tx_path_on = in_active;
   assign next_line_ctrl.battery_ring = in_ring;
   assign next_line_ctrl.metering_on = in_active && pins.mode_select_bit_a;

   // Gain table applies to the active transmission path
   assign next_gain.rx_gain_db = pins.gain_select ? SLMC_RX_DB_HIGH : SLMC_RX_DB_LOW;
   assign next_gain.tx_gain_db = pins.gain_select ? SLMC_TX_DB_HIGH : SLMC_TX_DB_LOW;
   assign next_gain.zsynth_scale = pins.gain_select ? SLMC_SCALE_HIGH : SLMC_SCALE_LOW;

   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         mode_out <= SLMC_ST_PDOWN;
         line_ctrl_out <= '{default: 1'b0, wires_hiz: 1'b1};
         gain_out <= '{SLMC_RX_DB_LOW, SLMC_TX_DB_LOW, SLMC_SCALE_LOW};
         battery_target_out <= SLMC_VBAT_IDLE;
         overheat_out <= 1'b0;
      end else begin
         mode_out <= eff_state;
         line_ctrl_out <= next_line_ctrl;
         gain_out <= next_gain;
         battery_target_out <= in_ring ? SLMC_VBAT_RING : SLMC_VBAT_IDLE;
         overheat_out <= overheat;
      end
   end

   // ****************************************
   // Hook status
   // ****************************************
   // One detector threshold serves hi-z and active alike
   logic hook_detect;

   assign hook_detect = ((in_hiz || in_active) && pins.offhook_detect)
                        || (in_ring && pins.ring_trip_detect);

   // Open drain: enable low only while pulling the pin low
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         hook_status_n_out <= 1'b1;
         hook_status_oe_n_out <= 1'b1;
      end else begin
         hook_status_n_out <= !hook_detect;
         hook_status_oe_n_out <= !hook_detect;
      end
   end

   // ****************************************
   // Polarity reversal ramp
   // ****************************************
   // Step period stands in for the timing capacitor
   localparam logic [RAMP_W-1:0] RAMP_TOP = '1;
   logic pol_target;
   logic [15:0] ramp_div;
   logic ramp_tick;
   logic [RAMP_W-1:0] next_ramp;

   assign ramp_tick = (ramp_div == 16'(RAMP_STEP_CYC - 1));
   // Reversed polarity heads for the top, normal for zero
   assign next_ramp = !ramp_tick ? reversal_ramp_out :
                      (pol_target && reversal_ramp_out != RAMP_TOP) ?
                         reversal_ramp_out + RAMP_W'(1) :
                      (!pol_target && reversal_ramp_out != '0) ?
                         reversal_ramp_out - RAMP_W'(1) : reversal_ramp_out;

   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         pol_target <= 1'b0;
         ramp_div <= 16'h0000;
         reversal_ramp_out <= '0;
      end else begin
         // Bit is ignored in power down and hi-z; target holds
         if (in_active || in_ring) begin
            pol_target <= pins.polarity_ring_bit;
         end
         ramp_div <= ramp_tick ? 16'h0000 : ramp_div + 16'h0001;
         reversal_ramp_out <= next_ramp;
      end
   end

   // ****************************************
   // Metering envelope and pulse
   // ****************************************
   // Envelope rises while bit A holds in active mode, then decays; tone comes from outside
   localparam logic [ENV_W-1:0] ENV_TOP = '1;
   logic [15:0] env_div;
   logic env_tick;
   logic [ENV_W-1:0] next_env;

   assign env_tick = (env_div == 16'(ENV_STEP_CYC - 1));
   assign next_env = !env_tick ? metering_envelope_out :
                     (next_line_ctrl.metering_on && metering_envelope_out != ENV_TOP) ?
                        metering_envelope_out + ENV_W'(1) :
                     (!next_line_ctrl.metering_on && metering_envelope_out != '0) ?
                        metering_envelope_out - ENV_W'(1) : metering_envelope_out;

   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         env_div <= 16'h0000;
         metering_envelope_out <= '0;
         metering_pulse_out <= 1'b0;
      end else begin
         env_div <= env_tick ? 16'h0000 : env_div + 16'h0001;
         metering_envelope_out <= next_env;
         // Tone needed through rise and decay, not only while A holds
         metering_pulse_out <= pins.metering_tone_clock
                               && (metering_envelope_out != '0);
      end
   end

   // ****************************************
   // Converter switching clock
   // ****************************************
   // Internal divider keeps the converter running with no external clock
   logic [6:0] sw_div;
   logic sw_int;
   logic sw_wrap;

   assign sw_wrap = (sw_div == 7'(SLMC_SWCLK_HALF_CYC - 1));

   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         sw_div <= SLMC_DIV_RST;
         sw_int <= 1'b0;
         switch_clock_out <= 1'b0;
      end else begin
         sw_div <= sw_wrap ? SLMC_DIV_RST : sw_div + 7'h01;
         if (sw_wrap) begin
            sw_int <= !sw_int;
         end
         switch_clock_out <= strap ? sw_int : pins.ext_switch_clock;
      end
   end

endmodule : slmc_mode_control

`default_nettype wire

// ### core/slmc_pkg.sv
/*
 * Shared constants and types of the line interface mode control.
 * Assumes a 10 MHz logic clock and pins already at logic levels.
 */
`default_nettype none

package slmc_pkg;

   // ****************************************
   // Operating modes, one-hot
   // ****************************************
   typedef enum logic [3:0] {
      SLMC_ST_PDOWN  = 4'h1,
      SLMC_ST_HIZ    = 4'h2,
      SLMC_ST_ACTIVE = 4'h4,
      SLMC_ST_RING   = 4'h8
   } slmc_state_type;

   // ****************************************
   // Carriers
   // ****************************************
   // Pins as they arrive, and after each synchroniser stage
   typedef struct packed {
      logic power_down_input;
      logic mode_select_bit_a;
      logic mode_select_bit_b;
      logic polarity_ring_bit;
      logic gain_select;
      logic metering_tone_clock;
      logic ext_switch_clock;
      logic temp_above_limit;
      logic temp_below_hyst;
      logic offhook_detect;
      logic ring_trip_detect;
   } slmc_pins_type;

   // Line stage controls
   typedef struct packed {
      logic driver_on;
      logic wires_hiz;
      logic detector_on;
      logic tx_path_on;
      logic battery_ring;
      logic metering_on;
   } slmc_line_ctrl_type;

   // Transmission gain set
   typedef struct packed {
      logic signed [4:0] rx_gain_db;
      logic signed [4:0] tx_gain_db;
      logic [5:0] zsynth_scale;
   } slmc_gain_type;

   // ****************************************
   // Figures and timing
   // ****************************************
   localparam logic signed [4:0] SLMC_RX_DB_LOW = 5'sh00;
   localparam logic signed [4:0] SLMC_RX_DB_HIGH = 5'sh06;
   localparam logic signed [4:0] SLMC_TX_DB_LOW = -5'sh06;
   localparam logic signed [4:0] SLMC_TX_DB_HIGH = -5'sh0c;
   localparam logic [5:0] SLMC_SCALE_LOW = 6'h32;
   localparam logic [5:0] SLMC_SCALE_HIGH = 6'h19;
   localparam logic signed [7:0] SLMC_VBAT_IDLE = -8'sh32;
   localparam logic signed [7:0] SLMC_VBAT_RING = -8'sh46;
   localparam int SLMC_CLK_KHZ = 10000;
   localparam int SLMC_SWCLK_KHZ = 125;
   localparam int SLMC_SWCLK_HALF_CYC = SLMC_CLK_KHZ / (2 * SLMC_SWCLK_KHZ);
   localparam int SLMC_SETTLE_NS = 500;
   localparam int SLMC_SETTLE_CYC = (SLMC_SETTLE_NS * SLMC_CLK_KHZ + 999999) / 1000000;
   localparam logic [3:0] SLMC_SETTLE_RST = 4'h0;
   localparam logic [6:0] SLMC_DIV_RST = 7'h00;

endpackage : slmc_pkg

`default_nettype wire

// ### sim/slmc_mode_control_props.sv
/* Port checker of the mode control.
   Assumes one clock and a synchronous active-low reset. */
`default_nettype none
module slmc_mode_control_props
   import slmc_pkg::*;
#(
   parameter int RAMP_W = 8,
   parameter int ENV_W = 6
) (
   // Clock, reset and pins
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic power_down_input_in,
   input wire logic mode_select_bit_a_in,
   input wire logic mode_select_bit_b_in,
   input wire logic temp_above_limit_in,
   input wire logic offhook_detect_in,
   // Outputs watched
   input wire logic hook_status_n_out,
   input wire logic hook_status_oe_n_out,
   input wire slmc_state_type mode_out,
   input wire slmc_line_ctrl_type line_ctrl_out,
   input wire logic signed [7:0] battery_target_out,
   input wire logic overheat_out,
   input wire logic [RAMP_W-1:0] reversal_ramp_out,
   input wire logic [ENV_W-1:0] metering_envelope_out,
   input wire logic metering_pulse_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [2:0] code;
   logic [2:0] prev_code;
   logic [7:0] stable_cnt;
   slmc_state_type exp_mode;
   // ****************************************
   // Expected mode once the pins have settled
   // ****************************************
   assign code = {power_down_input_in, mode_select_bit_a_in, mode_select_bit_b_in};
   assign exp_mode = !code[2] ? SLMC_ST_PDOWN : (code[1:0] == 2'h0) ? SLMC_ST_HIZ :
      code[0] ? SLMC_ST_ACTIVE : SLMC_ST_RING;
   // Age of the current pin code, so short glitches never qualify
   always_ff @(posedge clk_in) begin
      prev_code <= code;
      if (!resetn_in || code != prev_code) begin
         stable_cnt <= 8'h00;
      end else if (stable_cnt != 8'hff) begin
         stable_cnt <= stable_cnt + 8'h01;
      end
   end
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!resetn_in);
   a_decode_settled: assert property (
      code == prev_code && stable_cnt >= 8'h0e && !overheat_out && !$past(overheat_out) &&
      !$past(overheat_out, 2) |-> mode_out == exp_mode) else $error("mode decode wrong");
   a_pdown_line_off: assert property (
      mode_out == SLMC_ST_PDOWN |-> !line_ctrl_out.driver_on && line_ctrl_out.wires_hiz &&
      !line_ctrl_out.detector_on) else $error("line stage on in power down");
   a_pdown_hook_idle: assert property (
      (mode_out == SLMC_ST_PDOWN) [*4] |-> hook_status_n_out) else $error("hook in power down");
   a_hiz_hook_low: assert property (
      (mode_out == SLMC_ST_HIZ && offhook_detect_in) [*5] |-> !hook_status_n_out)
      else $error("off-hook missed in hi-z");
   a_hook_pin_drive: assert property (
      hook_status_oe_n_out == hook_status_n_out) else $error("hook enable differs");
   a_battery_target: assert property (
      battery_target_out == ((mode_out == SLMC_ST_RING) ? SLMC_VBAT_RING : SLMC_VBAT_IDLE))
      else $error("battery target wrong");
   a_tx_only_active: assert property (
      line_ctrl_out.tx_path_on == (mode_out == SLMC_ST_ACTIVE)) else $error("tx path wrong");
   a_heat_entry: assert property (
      temp_above_limit_in [*5] |-> overheat_out) else $error("overheat late");
   a_heat_forces_pdown: assert property (
      overheat_out && $past(overheat_out) |-> mode_out == SLMC_ST_PDOWN)
      else $error("overheat without power down");
   a_ramp_one_step: assert property (
      $changed(reversal_ramp_out) |-> reversal_ramp_out == $past(reversal_ramp_out) + 1'b1 ||
      reversal_ramp_out == $past(reversal_ramp_out) - 1'b1) else $error("ramp jumped");
   a_pulse_gated: assert property (
      metering_pulse_out |-> $past(metering_envelope_out) != '0) else $error("pulse ungated");
   c_ring: cover property (mode_out == SLMC_ST_RING);
   c_hook_low: cover property (!hook_status_n_out);
   c_pulse: cover property (metering_pulse_out);
   c_heat: cover property (overheat_out);
endmodule : slmc_mode_control_props
bind slmc_mode_control slmc_mode_control_props #(.RAMP_W(RAMP_W), .ENV_W(ENV_W)) u_props (
   .clk_in(clk_in), .resetn_in(resetn_in), .power_down_input_in(power_down_input_in),
   .mode_select_bit_a_in(mode_select_bit_a_in), .mode_select_bit_b_in(mode_select_bit_b_in),
   .temp_above_limit_in(temp_above_limit_in), .offhook_detect_in(offhook_detect_in),
   .hook_status_n_out(hook_status_n_out), .hook_status_oe_n_out(hook_status_oe_n_out),
   .mode_out(mode_out), .line_ctrl_out(line_ctrl_out), .overheat_out(overheat_out),
   .battery_target_out(battery_target_out), .reversal_ramp_out(reversal_ramp_out),
   .metering_envelope_out(metering_envelope_out), .metering_pulse_out(metering_pulse_out)
);
`default_nettype wire

// ### sim/slmc_ctrl_model.sv
/* Line card controller model: mode pins, ring cadence, tone clock.
   Assumes the bench picks the mode code and whether to ring. */
`default_nettype none
module slmc_ctrl_model
   import slmc_pkg::*;
#(
   parameter int RING_HALF_CYC = 600,
   parameter int TONE_HALF_CYC = 417
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic resetn_in,
   // Bench commands and device status
   input wire logic [2:0] cmd_code_in,
   input wire logic cmd_pol_in,
   input wire logic ring_run_in,
   input wire logic hook_status_n_in,
   // Pins to the device
   output logic power_down_input_out,
   output logic mode_select_bit_a_out,
   output logic mode_select_bit_b_out,
   output logic polarity_ring_bit_out,
   output var logic metering_tone_clock_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [9:0] ring_cnt;
   logic [9:0] tone_cnt;
   logic ring_pol;
   logic tripped;
   // Tone runs free; cadence runs only while ringing and untripped
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         ring_cnt <= 10'h000;
         tone_cnt <= 10'h000;
         ring_pol <= 1'b0;
         tripped <= 1'b0;
         metering_tone_clock_out <= 1'b0;
      end else begin
         tone_cnt <= (tone_cnt == 10'(TONE_HALF_CYC - 1)) ? 10'h000 : tone_cnt + 10'h001;
         if (tone_cnt == 10'(TONE_HALF_CYC - 1)) begin
            metering_tone_clock_out <= ~metering_tone_clock_out;
         end
         if (ring_run_in && !tripped) begin
            ring_cnt <= (ring_cnt == 10'(RING_HALF_CYC - 1)) ? 10'h000 : ring_cnt + 10'h001;
            if (ring_cnt == 10'(RING_HALF_CYC - 1)) begin
               ring_pol <= ~ring_pol;
            end
         end
         tripped <= ring_run_in && (tripped || !hook_status_n_in);
      end
   end
   // After a trip the cadence stops and the line returns to active
   assign {power_down_input_out, mode_select_bit_a_out, mode_select_bit_b_out} =
      tripped ? 3'h5 : cmd_code_in;
   assign polarity_ring_bit_out = (ring_run_in && !tripped) ? ring_pol : cmd_pol_in;
endmodule : slmc_ctrl_model
`default_nettype wire

// ### sim/slmc_mode_control_tb.sv
/* Self-checking bench of the mode control.
   Assumes the controller model drives the mode pins. */
`default_nettype none
module slmc_mode_control_tb
   import slmc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_in = 1'b0, resetn_in = 1'b0, cmd_pol = 1'b0, ring_run = 1'b0, gain_sel = 1'b0;
   logic sw_clk = 1'b0, strap = 1'b0, t_hi = 1'b0, t_lo = 1'b1, offhook = 1'b0, trip = 1'b0;
   logic [2:0] cmd_code = 3'h0;
   logic pd, ma, mb, pol, tone, hook_n, heat, pulse, sw_out, sw_prev;
   logic [1:0] hits;
   slmc_state_type mode;
   slmc_line_ctrl_type lc;
   slmc_gain_type gain;
   logic signed [7:0] batt;
   logic [7:0] ramp;
   logic [5:0] env;
   int error_cnt = 0, checks = 0, n;
   // Clock and a fast external converter clock, so strap choice shows
   always #50 clk_in = ~clk_in;
   always begin
      repeat (25) @(posedge clk_in);
      sw_clk <= ~sw_clk;
   end
   slmc_ctrl_model u_slmc_ctrl_model (.clk_in(clk_in), .resetn_in(resetn_in),
      .cmd_code_in(cmd_code), .cmd_pol_in(cmd_pol), .ring_run_in(ring_run),
      .hook_status_n_in(hook_n), .power_down_input_out(pd), .mode_select_bit_a_out(ma),
      .mode_select_bit_b_out(mb), .polarity_ring_bit_out(pol), .metering_tone_clock_out(tone));
   slmc_mode_control #(.RAMP_STEP_CYC(2), .ENV_STEP_CYC(2)) u_slmc_mode_control (
      .clk_in(clk_in), .resetn_in(resetn_in), .power_down_input_in(pd),
      .mode_select_bit_a_in(ma), .mode_select_bit_b_in(mb), .polarity_ring_bit_in(pol),
      .gain_select_in(gain_sel), .metering_tone_clock_in(tone), .switch_clock_in(sw_clk),
      .clock_tied_to_filter_in(strap), .temp_above_limit_in(t_hi), .temp_below_hyst_in(t_lo),
      .offhook_detect_in(offhook), .ring_trip_detect_in(trip), .hook_status_n_out(hook_n),
      .hook_status_oe_n_out(), .mode_out(mode), .line_ctrl_out(lc), .gain_out(gain),
      .battery_target_out(batt), .overheat_out(heat), .reversal_ramp_out(ramp),
      .metering_envelope_out(env), .metering_pulse_out(pulse), .switch_clock_out(sw_out));
   task automatic wt(input int k);
      repeat (k) @(posedge clk_in);
   endtask : wt
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // Drive a mode code at a rising edge, wait, then settle on a falling edge
   task automatic set_mode(input logic [2:0] c, input int k);
      @(posedge clk_in);
      cmd_code <= c;
      wt(k);
      @(negedge clk_in);
   endtask : set_mode
   task automatic sw_rate(input logic s, input int exp);
      @(posedge clk_in);
      strap <= s;
      wt(20);
      n = 0;
      sw_prev = sw_out;
      repeat (800) begin
         @(negedge clk_in);
         n += int'(sw_out !== sw_prev);
         sw_prev = sw_out;
      end
      chk(n >= exp - 1 && n <= exp + 1, 1'b1);
   endtask : sw_rate
   function automatic slmc_state_type exp_mode(input logic [2:0] c);
      return !c[2] ? SLMC_ST_PDOWN : (c[1:0] == 2'h0) ? SLMC_ST_HIZ :
         c[0] ? SLMC_ST_ACTIVE : SLMC_ST_RING;
   endfunction : exp_mode
   task automatic end_sim;
      if (error_cnt == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : end_sim
   // Watchdog well past the expected run of some 5300 cycles
   initial begin
      wt(20000);
      error_cnt++;
      end_sim();
   end
   // ****************************************
   // Test sequence
   // ****************************************
   initial begin
      wt(6);
      resetn_in <= 1'b1;
      @(negedge clk_in);
      chk({mode, lc, batt}, {SLMC_ST_PDOWN, 6'h10, SLMC_VBAT_IDLE});
      chk(gain, {SLMC_RX_DB_LOW, SLMC_TX_DB_LOW, SLMC_SCALE_LOW});
      for (int i = 0; i < 8; i++) begin
         set_mode(i[2:0], 16);
         chk(mode, exp_mode(i[2:0]));
         chk(batt, (i == 6) ? SLMC_VBAT_RING : SLMC_VBAT_IDLE);
         chk(lc.tx_path_on, i == 5 || i == 7);
         chk({lc.battery_ring, lc.driver_on}, {i == 6, i > 3});
      end
      // A three-cycle burst of active must never reach the line
      set_mode(3'h4, 16);
      set_mode(3'h5, 2);
      set_mode(3'h4, 0);
      repeat (14) begin
         @(negedge clk_in);
         chk(mode, SLMC_ST_HIZ);
      end
      @(posedge clk_in);
      offhook <= 1'b1;
      wt(5);
      @(negedge clk_in);
      chk(hook_n, 1'b0);
      set_mode(3'h0, 16);
      chk({hook_n, lc.detector_on}, 2'h2);
      @(posedge clk_in);
      offhook <= 1'b0;
      cmd_pol <= 1'b1;
      set_mode(3'h5, 100);
      chk(ramp != 8'h00 && ramp != 8'hff, 1'b1);
      wt(500);
      @(negedge clk_in);
      chk(ramp, 8'hff);
      @(posedge clk_in);
      gain_sel <= 1'b1;
      set_mode(3'h7, 200);
      chk(gain, {SLMC_RX_DB_HIGH, SLMC_TX_DB_HIGH, SLMC_SCALE_HIGH});
      chk({env, lc.metering_on}, 7'h7f);
      hits = 2'h0;
      repeat (900) begin
         @(negedge clk_in);
         hits[0] |= pulse;
      end
      chk(hits[0], 1'b1);
      set_mode(3'h5, 200);
      chk({env, pulse}, 7'h00);
      @(posedge clk_in);
      t_hi <= 1'b1;
      t_lo <= 1'b0;
      wt(6);
      @(negedge clk_in);
      chk({heat, mode}, {1'b1, SLMC_ST_PDOWN});
      @(posedge clk_in);
      t_hi <= 1'b0;
      t_lo <= 1'b1;
      wt(8);
      @(negedge clk_in);
      chk({heat, mode}, {1'b0, SLMC_ST_ACTIVE});
      // Ringing: ramp must swing both ways, then a trip ends it
      @(posedge clk_in);
      cmd_pol <= 1'b0;
      ring_run <= 1'b1;
      cmd_code <= 3'h6;
      hits = 2'h0;
      repeat (1500) begin
         @(negedge clk_in);
         hits |= {ramp == 8'hff, ramp == 8'h00};
      end
      chk({hits, mode}, {2'h3, SLMC_ST_RING});
      @(posedge clk_in);
      trip <= 1'b1;
      n = 0;
      while (hook_n !== 1'b0 && n < 10) begin
         @(negedge clk_in);
         n++;
      end
      chk(hook_n, 1'b0);
      wt(20);
      @(negedge clk_in);
      chk(mode, SLMC_ST_ACTIVE);
      @(posedge clk_in);
      trip <= 1'b0;
      ring_run <= 1'b0;
      sw_rate(1'b1, 20);
      sw_rate(1'b0, 32);
      end_sim();
   end
endmodule : slmc_mode_control_tb
`default_nettype wire
